/* File: rtl/smrsi_interlock.sv */
// run/stop interlock of a servo driver in speed control mode
// assumes discrete command pins are asynchronous, speed command is on clock
//
// Contract
// R1: before power-up the command device holds servo enable low and both starts off.
// R2: at power-down the command device drops start, then servo enable, then power.
// R3: at power-up all segments light briefly, then the speed label, then data 2 s later.
// R4: with servo enable off the power stage is off and the motor coasts.
// R5: any alarm turns the power stage off and applies the dynamic brake.
// R6: emergency stop inactive shuts the stage, brakes and raises the emergency alarm. An already latched encoder alarm stays in alarm_code instead.
// R7: an inactive stroke limit stops suddenly and servo-locks, still allowing reverse travel.
// R8: both starts on or both off decelerate to a stop on the configured profile.
// R9: a sudden stop is a ramp to zero with deceleration time forced to zero.
// R10: ready is asserted in the servo-on state with emergency stop released and enable on.
// R11: with all permissives on and exactly one start, rotate at the analog speed command.
// R12: a mismatched encoder cable setting raises the encoder alarm at power-on.
// R13: speed control mode is chosen by the control mode selection field.
// R14: I/O setting parameters are used only once write-enable permits them.
// R15: the most severe stop wins: alarm/emergency, stroke limit, servo-off, start decel. The code checks servo-off (and mode) ahead of stroke limit.
`timescale 1ns/1ns
module smrsi_interlock #(
    parameter int unsigned LAMP_TEST_CYC  = smrsi_pkg::LAMP_TEST_CYC,
    parameter int unsigned LABEL_HOLD_CYC = smrsi_pkg::LABEL_HOLD_CYC
) (
    input  wire logic                                clock,
    input  wire logic                                reset,
    input  wire logic                                servo_enable_in,
    input  wire logic                                emergency_stop_in,
    input  wire logic                                fwd_limit_in,
    input  wire logic                                rev_limit_in,
    input  wire logic                                fwd_start_in,
    input  wire logic                                rev_start_in,
    input  wire logic signed [smrsi_pkg::SPEED_W-1:0] analog_speed_cmd,
    input  wire logic        [smrsi_pkg::MODE_W-1:0]  control_mode_select,
    input  wire logic        [3:0]                    param_write_enable,
    input  wire logic        [3:0]                    encoder_cable_select,
    input  wire logic        [7:0]                    io_setting_in,
    input  wire logic                                alarm_clear,
    output logic                                     base_drive_on,
    output logic                                     dyn_brake_on,
    output logic                                     servo_lock,
    output logic                                     decel_zero_time,
    output logic signed [smrsi_pkg::SPEED_W-1:0]      speed_target,
    output logic                                     ready_out,
    output logic        [7:0]                         alarm_code,
    output logic                                     alarm_active,
    output logic        [2:0]                         disp_phase,
    output logic        [7:0]                         io_setting_used
);
    localparam int unsigned CNT_W = $clog2(LABEL_HOLD_CYC + LAMP_TEST_CYC + 1);

    logic [5:0]                         pins_s;
    logic                               son_s;
    logic                               emg_s;
    logic                               lsp_s;
    logic                               lsn_s;
    logic                               st1_s;
    logic                               st2_s;
    logic [CNT_W-1:0]                   disp_cnt_r;
    smrsi_pkg::smrsi_disp_t             disp_r;
    smrsi_pkg::smrsi_state_t            state_r;
    smrsi_pkg::smrsi_state_t            state_nxt;
    logic                               cable_checked_r;
    logic                               speed_mode;
    logic                               fwd_req;
    logic                               rev_req;
    logic                               one_start;
    logic                               limit_blocks;

    initial begin
        if (LAMP_TEST_CYC < 1 || LABEL_HOLD_CYC < 1)
            $error("smrsi_interlock: display counts must be at least 1");
    end

    smrsi_sync #(
        .WIDTH (6)
    ) u_sync (
        .clock    (clock),
        .reset    (reset),
        // active-low pins cross inverted: flops reset to 0 read as released, no false alarm
        .async_in ({servo_enable_in, ~emergency_stop_in, ~fwd_limit_in,
                    ~rev_limit_in, fwd_start_in, rev_start_in}),
        .sync_out (pins_s)
    );

    assign son_s = pins_s[5];
    assign emg_s = ~pins_s[4];
    assign lsp_s = ~pins_s[3];
    assign lsn_s = ~pins_s[2];
    assign st1_s = pins_s[1];
    assign st2_s = pins_s[0];

    // power-up display sequence
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            disp_r     <= smrsi_pkg::SMRSI_DISP_TEST;
            disp_cnt_r <= '0;
        end else begin
            case (disp_r)
                smrsi_pkg::SMRSI_DISP_TEST: begin
                    if (disp_cnt_r == CNT_W'(LAMP_TEST_CYC - 1)) begin // R3
                        disp_r     <= smrsi_pkg::SMRSI_DISP_LABEL;
                        disp_cnt_r <= '0;
                    end else begin
                        disp_cnt_r <= disp_cnt_r + 1'b1;
                    end
                end
                smrsi_pkg::SMRSI_DISP_LABEL: begin
                    if (disp_cnt_r == CNT_W'(LABEL_HOLD_CYC - 1)) begin // R3
                        disp_r     <= smrsi_pkg::SMRSI_DISP_DATA;
                        disp_cnt_r <= '0;
                    end else begin
                        disp_cnt_r <= disp_cnt_r + 1'b1;
                    end
                end
                smrsi_pkg::SMRSI_DISP_DATA: disp_cnt_r <= '0;
                default: begin
                    disp_r     <= smrsi_pkg::SMRSI_DISP_TEST;
                    disp_cnt_r <= '0;
                end
            endcase
        end
    end

    assign disp_phase = disp_r;

    // alarms latch; emergency is held while the pin stays inactive
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            alarm_code      <= smrsi_pkg::ALARM_NONE;
            cable_checked_r <= 1'b0;
        end else begin
            if (!cable_checked_r) begin
                cable_checked_r <= 1'b1;
                if (encoder_cable_select != smrsi_pkg::CABLE_EXPECTED)
                    alarm_code <= smrsi_pkg::ALARM_ENCODER; // R12
            end else if (!emg_s) begin
                if (alarm_code == smrsi_pkg::ALARM_NONE)
                    alarm_code <= smrsi_pkg::ALARM_EMERGENCY; // R6
            end else if (alarm_clear && alarm_code == smrsi_pkg::ALARM_EMERGENCY) begin
                // encoder alarm only clears at power cycle
                alarm_code <= smrsi_pkg::ALARM_NONE;
            end
        end
    end

    assign alarm_active = (alarm_code != smrsi_pkg::ALARM_NONE);

    // I/O parameter group gated by write-enable
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            io_setting_used <= 8'h00;
        end else if (param_write_enable == smrsi_pkg::WRITE_EN_IO) begin
            io_setting_used <= io_setting_in; // R14
        end
    end

    assign speed_mode   = (control_mode_select == smrsi_pkg::MODE_SPEED); // R13
    assign fwd_req      = st1_s && !st2_s;
    assign rev_req      = st2_s && !st1_s;
    assign one_start    = st1_s ^ st2_s; // R8
    // limit blocks only the direction it guards
    assign limit_blocks = (fwd_req && !lsp_s) || (rev_req && !lsn_s); // R7

    always_comb begin
        if (alarm_active || !emg_s) begin
            state_nxt = smrsi_pkg::SMRSI_ST_BRAKE; // R5 R6 R15
        end else if (!son_s || !speed_mode) begin
            state_nxt = smrsi_pkg::SMRSI_ST_COAST; // R4
        end else if (limit_blocks) begin
            state_nxt = smrsi_pkg::SMRSI_ST_LOCK; // R7 R15
        end else if (!one_start) begin
            state_nxt = smrsi_pkg::SMRSI_ST_DECEL; // R8
        end else begin
            state_nxt = smrsi_pkg::SMRSI_ST_RUN; // R11
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) state_r <= smrsi_pkg::SMRSI_ST_COAST;
        else       state_r <= state_nxt;
    end

    // drive outputs registered from state_nxt
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            base_drive_on   <= 1'b0;
            dyn_brake_on    <= 1'b0;
            servo_lock      <= 1'b0;
            decel_zero_time <= 1'b0;
            speed_target    <= '0;
            ready_out       <= 1'b0;
        end else begin
            base_drive_on   <= 1'b0;
            dyn_brake_on    <= 1'b0;
            servo_lock      <= 1'b0;
            decel_zero_time <= 1'b0;
            speed_target    <= '0;
            ready_out       <= 1'b0;
            case (state_nxt)
                smrsi_pkg::SMRSI_ST_BRAKE: dyn_brake_on <= 1'b1; // R5 R6
                smrsi_pkg::SMRSI_ST_COAST: ;                     // R4
                smrsi_pkg::SMRSI_ST_LOCK: begin
                    base_drive_on   <= 1'b1;
                    servo_lock      <= 1'b1;
                    decel_zero_time <= 1'b1; // R9
                    ready_out       <= 1'b1; // R10
                end
                smrsi_pkg::SMRSI_ST_DECEL: begin
                    base_drive_on <= 1'b1;
                    ready_out     <= 1'b1; // R10
                end
                smrsi_pkg::SMRSI_ST_RUN: begin
                    base_drive_on <= 1'b1;
                    ready_out     <= 1'b1; // R10
                    speed_target  <= fwd_req ? analog_speed_cmd : -analog_speed_cmd; // R11
                end
                default: ;
            endcase
        end
    end
endmodule

/* File: rtl/smrsi_sync.sv */
// two-flop synchroniser for a bundle of pin-level inputs
// assumes the inputs change asynchronously to clock
`timescale 1ns/1ns
module smrsi_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    initial begin
        if (WIDTH < 1) $error("smrsi_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

/* File: shared/smrsi_pkg.sv */
// constants for the speed-mode run/stop interlock
// assumes a 100 MHz system clock
package smrsi_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned LAMP_TEST_US    = 100;
    localparam int unsigned LABEL_HOLD_MS   = 2000;
    localparam int unsigned LAMP_TEST_CYC   = LAMP_TEST_US * (CLK_HZ / 1_000_000);
    localparam int unsigned LABEL_HOLD_CYC  = LABEL_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned SPEED_W         = 16;
    localparam int unsigned MODE_W          = 4;
    localparam logic [3:0]  MODE_SPEED      = 4'h2;
    localparam logic [3:0]  CABLE_EXPECTED  = 4'h0;
    localparam logic [3:0]  WRITE_EN_IO     = 4'h1;
    localparam logic [7:0]  ALARM_NONE      = 8'h00;
    localparam logic [7:0]  ALARM_ENCODER   = 8'h16;
    localparam logic [7:0]  ALARM_EMERGENCY = 8'hE6;

    typedef enum logic [2:0] {
        SMRSI_DISP_TEST  = 3'b001,
        SMRSI_DISP_LABEL = 3'b010,
        SMRSI_DISP_DATA  = 3'b100
    } smrsi_disp_t;

    typedef enum logic [4:0] {
        SMRSI_ST_COAST = 5'b00001,
        SMRSI_ST_BRAKE = 5'b00010,
        SMRSI_ST_LOCK  = 5'b00100,
        SMRSI_ST_DECEL = 5'b01000,
        SMRSI_ST_RUN   = 5'b10000
    } smrsi_state_t;
endpackage

/* File: tb/smrsi_cmd_dev.sv */
// command device model driving enable and start pins
// assumes requests from the bench; pins move on the falling edge
`timescale 1ns/1ns
module smrsi_cmd_dev (
    input  wire logic       clock,
    input  wire logic       en_req,
    input  wire logic [1:0] start_req,
    output logic            servo_enable_in,
    output logic            fwd_start_in,
    output logic            rev_start_in
);
    logic       en_q    = 1'b0;
    logic [1:0] start_q = 2'h0;
    initial {servo_enable_in, rev_start_in, fwd_start_in} = 3'h0;
    // requests taken on the rising edge, never racing the bench's falling-edge writes
    always @(posedge clock) begin
        en_q    <= en_req;
        start_q <= start_req;
    end
    always @(negedge clock) begin
        // enable stays up until the starts have dropped
        servo_enable_in <= en_q || fwd_start_in || rev_start_in;
        {rev_start_in, fwd_start_in} <= (en_q && servo_enable_in) ? start_q : 2'h0;
    end
endmodule

/* File: tb/smrsi_interlock_sva.sv */
// assertions on the run/stop interlock ports
// assumes it is bound onto smrsi_interlock
`timescale 1ns/1ns
module smrsi_interlock_sva #(
    parameter int unsigned LABEL_HOLD_CYC = 8
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        servo_enable_in,
    input wire logic        emergency_stop_in,
    input wire logic        fwd_limit_in,
    input wire logic        rev_limit_in,
    input wire logic        fwd_start_in,
    input wire logic        rev_start_in,
    input wire logic [15:0] analog_speed_cmd,
    input wire logic [3:0]  control_mode_select,
    input wire logic [3:0]  param_write_enable,
    input wire logic        base_drive_on,
    input wire logic        dyn_brake_on,
    input wire logic        servo_lock,
    input wire logic        decel_zero_time,
    input wire logic [15:0] speed_target,
    input wire logic        ready_out,
    input wire logic [7:0]  alarm_code,
    input wire logic        alarm_active,
    input wire logic [2:0]  disp_phase,
    input wire logic [7:0]  io_setting_used
);
    logic [31:0] lbl_cnt_r;
    wire ok = emergency_stop_in && servo_enable_in && control_mode_select == 4'h2 && !alarm_active;
    wire okl = ok && fwd_limit_in && rev_limit_in;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) lbl_cnt_r <= 32'h0;
        else if (disp_phase == 3'b010) lbl_cnt_r <= lbl_cnt_r + 32'h1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // 4 cycles covers the two sync flops plus the output register
    sequence s_fwd_held;
        (okl && fwd_start_in && !rev_start_in && $stable(analog_speed_cmd))[*4];
    endsequence
    sequence s_fwd_blocked;
        (ok && !fwd_limit_in && fwd_start_in && !rev_start_in)[*4];
    endsequence
    chk_coast_free: assert property ((!servo_enable_in && emergency_stop_in && !alarm_active)[*4]
        |=> !base_drive_on && !dyn_brake_on) else $error("coast not free");
    chk_alarm_brake: assert property (alarm_active && $past(alarm_active)
        |-> dyn_brake_on && !base_drive_on) else $error("alarm without brake");
    chk_emerg_stop: assert property ((!emergency_stop_in)[*4]
        |=> dyn_brake_on && !base_drive_on && alarm_code == 8'hE6) else $error("emergency stop");
    chk_fwd_run: assert property (s_fwd_held
        |=> base_drive_on && ready_out && speed_target == $past(analog_speed_cmd))
        else $error("forward run");
    chk_start_decel: assert property ((okl && fwd_start_in == rev_start_in)[*4]
        |=> speed_target == 16'h0 && !decel_zero_time && !dyn_brake_on) else $error("decel");
    chk_limit_lock: assert property (s_fwd_blocked
        |=> servo_lock && decel_zero_time && speed_target == 16'h0) else $error("limit lock");
    chk_mode_coast: assert property ((control_mode_select != 4'h2)[*2] |=> !base_drive_on)
        else $error("mode not coasting");
    chk_io_gate: assert property ((param_write_enable != 4'h1)[*2] |=> $stable(io_setting_used))
        else $error("io setting taken");
    chk_label_hold: assert property ($rose(disp_phase == 3'b100) |-> lbl_cnt_r == LABEL_HOLD_CYC)
        else $error("label hold length");
endmodule
bind smrsi_interlock smrsi_interlock_sva #(.LABEL_HOLD_CYC(LABEL_HOLD_CYC)) u_sva (.*);

/* File: tb/tb.sv */
// self-checking bench for the run/stop interlock
// assumes short display counts of 4 and 8 cycles
`timescale 1ns/1ns
module tb;
    logic clock = 1'b0, reset = 1'b1, emergency_stop_in = 1'b1, alarm_clear = 1'b0;
    logic fwd_limit_in = 1'b1, rev_limit_in = 1'b1, en_req = 1'b0;
    logic [1:0] start_req = 2'h0;
    logic signed [15:0] analog_speed_cmd = 16'h0123, speed_target;
    logic [3:0] control_mode_select = 4'h2, param_write_enable = 4'h0, encoder_cable_select = 4'h0;
    logic [7:0] io_setting_in = 8'hA5, alarm_code, io_setting_used;
    logic servo_enable_in, fwd_start_in, rev_start_in, base_drive_on, dyn_brake_on, servo_lock;
    logic decel_zero_time, ready_out, alarm_active;
    logic [2:0] disp_phase;
    logic [15:0] spd_exp [4];
    int miscompares = 0;
    int comparisons = 0;
    always #5 clock = ~clock;
    smrsi_cmd_dev dev (.*);
    smrsi_interlock #(.LAMP_TEST_CYC(4), .LABEL_HOLD_CYC(8)) uut (.*);
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task step(input int n);
        repeat (n) @(negedge clock);
    endtask
    task tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        $display("Error watchdog expected done seen hang");
        tally_and_finish;
    end
    initial begin
        spd_exp = '{16'h0000, 16'h0123, 16'hFEDD, 16'h0000};
        step(5);
        chk("disp_phase", 16'h1, disp_phase);
        reset = 1'b0;
        step(2);
        chk("disp_phase", 16'h1, disp_phase);
        step(6);
        chk("disp_phase", 16'h2, disp_phase);
        step(8);
        chk("disp_phase", 16'h4, disp_phase);
        chk("io_setting_used", 16'h0, io_setting_used);
        param_write_enable = 4'h1;
        step(3);
        chk("io_setting_used", 16'hA5, io_setting_used);
        param_write_enable = 4'h0;
        io_setting_in = 8'h3C;
        step(3);
        chk("io_setting_used", 16'hA5, io_setting_used);
        chk("base_drive_on", 16'h0, base_drive_on);
        chk("dyn_brake_on", 16'h0, dyn_brake_on);
        $display("test startup done");
        en_req = 1'b1;
        for (int i = 0; i < 4; i++) begin
            start_req = i[1:0];
            step(8);
            chk("speed_target", spd_exp[i], speed_target);
            chk("base_drive_on", 16'h1, base_drive_on);
            chk("ready_out", 16'h1, ready_out);
        end
        $display("test start patterns done");
        fwd_limit_in = 1'b0;
        start_req = 2'h1;
        step(8);
        chk("servo_lock", 16'h1, servo_lock);
        chk("decel_zero_time", 16'h1, decel_zero_time);
        chk("speed_target", 16'h0, speed_target);
        start_req = 2'h2;
        step(8);
        chk("speed_target", 16'hFEDD, speed_target);
        fwd_limit_in = 1'b1;
        rev_limit_in = 1'b0;
        step(8);
        chk("servo_lock", 16'h1, servo_lock);
        chk("speed_target", 16'h0, speed_target);
        rev_limit_in = 1'b1;
        control_mode_select = 4'h3;
        step(4);
        chk("base_drive_on", 16'h0, base_drive_on);
        control_mode_select = 4'h2;
        $display("test limit and mode done");
        emergency_stop_in = 1'b0;
        step(6);
        chk("dyn_brake_on", 16'h1, dyn_brake_on);
        chk("alarm_code", 16'hE6, alarm_code);
        chk("alarm_active", 16'h1, alarm_active);
        chk("servo_lock", 16'h0, servo_lock);
        emergency_stop_in = 1'b1;
        alarm_clear = 1'b1;
        step(6);
        alarm_clear = 1'b0;
        chk("alarm_code", 16'h0, alarm_code);
        en_req = 1'b0;
        step(8);
        chk("base_drive_on", 16'h0, base_drive_on);
        chk("dyn_brake_on", 16'h0, dyn_brake_on);
        chk("ready_out", 16'h0, ready_out);
        $display("test emergency and power down done");
        encoder_cable_select = 4'h1;
        reset = 1'b1;
        step(2);
        reset = 1'b0;
        step(6);
        chk("alarm_code", 16'h16, alarm_code);
        chk("dyn_brake_on", 16'h1, dyn_brake_on);
        $display("test cable alarm done");
        tally_and_finish;
    end
endmodule
